// ---- verilog/sfdph_pkg.sv ----
// Constants and types of the discoverable-parameter header content block
// =====================================================================
package sfdph_pkg;

    // =================================================================
    // Address layout
    localparam int ADDR_W = 24;
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [23:0] ADDR_STEP = 24'h000001;
    localparam logic [23:0] HDR_LAST = 24'h000017;

    // =================================================================
    // Header content
    localparam logic [7:0] SIG_0 = 8'h53;
    localparam logic [7:0] SIG_1 = 8'h46;
    localparam logic [7:0] SIG_2 = 8'h44;
    localparam logic [7:0] SIG_3 = 8'h50;
    localparam logic [7:0] STD_MINOR = 8'h08;
    localparam logic [7:0] STD_MAJOR = 8'h01;
    localparam logic [7:0] HDR_COUNT = 8'h01;
    localparam logic [7:0] ACC_PROTO = 8'hFF;
    localparam logic [7:0] H0_ID_LSB = 8'h00;
    localparam logic [7:0] H0_MINOR = 8'h07;
    localparam logic [7:0] H0_MAJOR = 8'h01;
    localparam logic [7:0] H0_LEN = 8'h10;
    localparam logic [7:0] H0_PTR_0 = 8'h30;
    localparam logic [7:0] H0_PTR_1 = 8'h00;
    localparam logic [7:0] H0_PTR_2 = 8'h00;
    localparam logic [7:0] H0_ID_MSB = 8'hFF;
    // Arbitrary neutral value, stands in for the maker code
    localparam logic [7:0] H1_ID = 8'hA5;
    localparam logic [7:0] H1_MINOR = 8'h00;
    localparam logic [7:0] H1_MAJOR = 8'h01;
    localparam logic [7:0] H1_LEN = 8'h03;
    localparam logic [7:0] H1_PTR_0 = 8'h70;
    localparam logic [7:0] H1_PTR_1 = 8'h00;
    localparam logic [7:0] H1_PTR_2 = 8'h00;
    localparam logic [7:0] H_UNUSED = 8'hFF;
    // Beyond the header the tables live elsewhere
    localparam logic [7:0] OUT_FILL = 8'hFF;
    localparam logic [7:0] DATA_RST = 8'h00;

    // =================================================================
    // Types
    typedef enum logic {
        SFDPH_IDLE,
        SFDPH_READ
    } sfdph_state_e;

    typedef struct packed {
        logic start;
        logic next;
        logic stop;
        logic write;
        logic [23:0] addr;
    } sfdph_req_s;

endpackage

// ---- verilog/sfdph_rom.sv ----
// Read-only header content with sequential byte access
`timescale 1ns/1ns

module sfdph_rom (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire sfdph_pkg::sfdph_req_s i_req,
    output logic [7:0] o_data,
    output logic o_valid,
    output logic o_active,
    output logic o_wr_reject
);

    // =================================================================
    // State
    typedef struct packed {
        sfdph_pkg::sfdph_state_e state;
        logic [23:0] addr;
        // Source of the shown byte, kept so the checks can see it
        logic [23:0] last_addr;
        logic [7:0] data;
        logic valid;
        logic active;
        logic wr_reject;
    } sfdph_st_s;

    sfdph_st_s st_q;
    sfdph_st_s st_d;

    // =================================================================
    // Content lookup
    // Past the header the space reads as fill; the tables live outside this block
    function automatic logic [7:0] sfdph_byte(input logic [23:0] a);
        logic [7:0] b;
        b = sfdph_pkg::OUT_FILL;
        if (a <= sfdph_pkg::HDR_LAST) begin
            unique case (a[4:0])
                5'h00: b = sfdph_pkg::SIG_0;
                5'h01: b = sfdph_pkg::SIG_1;
                5'h02: b = sfdph_pkg::SIG_2;
                5'h03: b = sfdph_pkg::SIG_3;
                5'h04: b = sfdph_pkg::STD_MINOR;
                5'h05: b = sfdph_pkg::STD_MAJOR;
                5'h06: b = sfdph_pkg::HDR_COUNT;
                5'h07: b = sfdph_pkg::ACC_PROTO;
                5'h08: b = sfdph_pkg::H0_ID_LSB;
                5'h09: b = sfdph_pkg::H0_MINOR;
                5'h0A: b = sfdph_pkg::H0_MAJOR;
                5'h0B: b = sfdph_pkg::H0_LEN;
                5'h0C: b = sfdph_pkg::H0_PTR_0;
                5'h0D: b = sfdph_pkg::H0_PTR_1;
                5'h0E: b = sfdph_pkg::H0_PTR_2;
                5'h0F: b = sfdph_pkg::H0_ID_MSB;
                5'h10: b = sfdph_pkg::H1_ID;
                5'h11: b = sfdph_pkg::H1_MINOR;
                5'h12: b = sfdph_pkg::H1_MAJOR;
                5'h13: b = sfdph_pkg::H1_LEN;
                5'h14: b = sfdph_pkg::H1_PTR_0;
                5'h15: b = sfdph_pkg::H1_PTR_1;
                5'h16: b = sfdph_pkg::H1_PTR_2;
                5'h17: b = sfdph_pkg::H_UNUSED;
                default: b = sfdph_pkg::OUT_FILL;
            endcase
        end
        return b;
    endfunction

    // =================================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.valid = 1'b0;
        // No path into the content exists; writes only earn a refusal
        st_d.wr_reject = i_req.write;
        unique case (st_q.state)
            sfdph_pkg::SFDPH_IDLE: begin
                if (i_req.start) begin
                    st_d.state = sfdph_pkg::SFDPH_READ;
                    st_d.active = 1'b1;
                    st_d.addr = i_req.addr;
                end
            end
            sfdph_pkg::SFDPH_READ: begin
                if (i_req.start) begin
                    // A fresh start restarts the walk; a same-cycle next is dropped
                    st_d.addr = i_req.addr;
                end else if (i_req.stop) begin
                    // Stop wins over next, so a late next never shows a byte
                    st_d.state = sfdph_pkg::SFDPH_IDLE;
                    st_d.active = 1'b0;
                end else if (i_req.next) begin
                    st_d.data = sfdph_byte(st_q.addr);
                    st_d.valid = 1'b1;
                    st_d.last_addr = st_q.addr;
                    // Wraps at the top of the 24-bit space
                    st_d.addr = st_q.addr + sfdph_pkg::ADDR_STEP;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q.state <= sfdph_pkg::SFDPH_IDLE;
            st_q.addr <= sfdph_pkg::ADDR_RST;
            st_q.last_addr <= sfdph_pkg::ADDR_RST;
            st_q.data <= sfdph_pkg::DATA_RST;
            st_q.valid <= 1'b0;
            st_q.active <= 1'b0;
            st_q.wr_reject <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_data = st_q.data;
    assign o_valid = st_q.valid;
    assign o_active = st_q.active;
    assign o_wr_reject = st_q.wr_reject;

    // =================================================================
    // Checks
    a_sig_bytes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && (st_q.last_addr[23:2] == 22'h000000) |->
            o_data == ((st_q.last_addr[1:0] == 2'h0) ? 8'h53 :
                       (st_q.last_addr[1:0] == 2'h1) ? 8'h46 :
                       (st_q.last_addr[1:0] == 2'h2) ? 8'h44 : 8'h50))
        else $error("signature byte wrong");

    a_std_minor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000004 |-> o_data == 8'h08)
        else $error("standard minor revision wrong");

    a_std_major: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000005 |-> o_data == 8'h01)
        else $error("standard major revision wrong");

    a_hdr_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000006 |-> o_data == 8'h01)
        else $error("header count wrong");

    a_acc_proto: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000007 |-> o_data == 8'hFF)
        else $error("access protocol wrong");

    a_h0_id_lsb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000008 |-> o_data == 8'h00)
        else $error("first header id low byte wrong");

    a_h0_rev: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && (st_q.last_addr == 24'h000009 || st_q.last_addr == 24'h00000A) |->
            o_data == (st_q.last_addr[0] ? 8'h07 : 8'h01))
        else $error("basic table revision wrong");

    a_h0_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h00000B |-> o_data == 8'h10)
        else $error("basic table length wrong");

    a_h0_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr >= 24'h00000C && st_q.last_addr <= 24'h00000E |->
            o_data == ((st_q.last_addr == 24'h00000C) ? 8'h30 : 8'h00))
        else $error("basic table pointer wrong");

    a_h0_id_msb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h00000F |-> o_data == 8'hFF)
        else $error("first header id high byte wrong");

    a_h1_id: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr == 24'h000010 |-> o_data == sfdph_pkg::H1_ID)
        else $error("second header id wrong");

    a_h1_fields: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr >= 24'h000011 && st_q.last_addr <= 24'h000013 |->
            o_data == ((st_q.last_addr == 24'h000011) ? 8'h00 :
                       (st_q.last_addr == 24'h000012) ? 8'h01 : 8'h03))
        else $error("second header fields wrong");

    a_h1_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr >= 24'h000014 && st_q.last_addr <= 24'h000017 |->
            o_data == ((st_q.last_addr == 24'h000014) ? 8'h70 :
                       (st_q.last_addr == 24'h000017) ? 8'hFF : 8'h00))
        else $error("vendor table pointer wrong");

    a_write_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.write |=> o_wr_reject)
        else $error("write not refused");

    a_write_no_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.write && !i_req.next |=> !o_valid)
        else $error("write produced data");

    a_first_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.start ##1 (i_req.next && !i_req.start && !i_req.stop) |=>
            o_valid && st_q.last_addr == $past(i_req.addr, 2))
        else $error("first byte not from start address");

    a_valid_from_next: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid |-> $past(o_active) && $past(i_req.next) && !$past(i_req.start) &&
            !$past(i_req.stop))
        else $error("byte returned without a taken next");

    a_consecutive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.next && !i_req.start && !i_req.stop ##1
            (i_req.next && !i_req.start && !i_req.stop) |=>
            st_q.last_addr == $past(st_q.last_addr) + 24'h000001)
        else $error("bytes not consecutive");

    a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_active && !i_req.start |=> !o_valid && !o_active)
        else $error("activity while idle");

    // =================================================================
    // Access framing checks
    a_active_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.start |=> o_active)
        else $error("start did not open an access");

    a_active_needs_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !$past(o_active) && o_active |-> $past(i_req.start))
        else $error("access opened without a start");

    a_active_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && !(i_req.stop && !i_req.start) |=> o_active)
        else $error("access closed without a stop");

    a_stop_closes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.stop && !i_req.start |=> !o_active && !o_valid)
        else $error("stop did not close the access");

    a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_active && i_req.stop && !i_req.start |=> !o_active)
        else $error("stop while idle opened an access");

    a_restart_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.start |=> o_active && !o_valid)
        else $error("restart returned a byte");

    a_next_stop_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.next && i_req.stop && !i_req.start |=> !o_valid)
        else $error("next with stop returned a byte");

    // =================================================================
    // Address walk checks
    a_addr_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.start |=> st_q.addr == $past(i_req.addr))
        else $error("start address not loaded");

    a_addr_next: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.next && !i_req.start && !i_req.stop |=>
            st_q.addr == $past(st_q.addr) + 24'h000001 &&
            st_q.last_addr == $past(st_q.addr))
        else $error("address did not step by one");

    a_addr_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_active && i_req.next && !i_req.start && !i_req.stop &&
            st_q.addr == 24'hFFFFFF |=> st_q.addr == 24'h000000)
        else $error("address did not wrap to zero");

    a_addr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_req.start && !(o_active && i_req.next && !i_req.stop) |=>
            st_q.addr == $past(st_q.addr))
        else $error("address moved without a request");

    a_last_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_valid && $past(i_rst_n) |-> $stable(st_q.last_addr))
        else $error("source address moved without a byte");

    a_data_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_valid && $past(i_rst_n) |-> $stable(o_data))
        else $error("data changed without a byte");

    // =================================================================
    // Content range checks
    a_out_fill: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && st_q.last_addr > 24'h000017 |-> o_data == 8'hFF)
        else $error("byte past the header not fill");

    a_sig_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.start && i_req.addr == 24'h000000 ##1
            (i_req.next && !i_req.start && !i_req.stop) |=> o_data == 8'h53)
        else $error("entry point does not return the signature");

    // =================================================================
    // Write protection checks
    a_reject_from_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_wr_reject |-> $past(i_req.write))
        else $error("refusal without a write");

    a_reject_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_req.write |=> !o_wr_reject)
        else $error("refusal stretched past its write");

    a_write_keeps_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.write && !i_req.start && !i_req.next |=> st_q.addr == $past(st_q.addr))
        else $error("write moved the address");

    a_write_keeps_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.write && !i_req.start && !i_req.stop |=> o_active == $past(o_active))
        else $error("write changed the access state");

    a_write_keeps_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.write && !(o_active && i_req.next) |=> o_data == $past(o_data))
        else $error("write changed the shown byte");

    // =================================================================
    // Reset checks
    a_reset_values: assert property (@(posedge i_clk)
        !i_rst_n |=> !o_valid && !o_active && !o_wr_reject && o_data == 8'h00)
        else $error("outputs not cleared by reset");

endmodule // sfdph_rom

// ---- verif/sfdph_host_model.sv ----
// Host controller model that frames header read requests
`timescale 1ns/1ns

module sfdph_host_model (
    output sfdph_pkg::sfdph_req_s o_req
);
    initial begin
        o_req = '0;
    end

    // Called just after a falling edge; held until the next call, one clock or more
    task automatic drive(input logic s, input logic n, input logic p, input logic w,
                         input logic [23:0] a);
        o_req.start = s;
        o_req.next = n;
        o_req.stop = p;
        o_req.write = w;
        // Address only means something with start, so it never idles stale
        o_req.addr = s ? a : ~o_req.addr;
    endtask
endmodule // sfdph_host_model

// ---- verif/tb_sfdph_rom.sv ----
// Self-checking bench for the header content block
`timescale 1ns/1ns

module tb_sfdph_rom;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    sfdph_pkg::sfdph_req_s req;
    logic [7:0] o_data;
    logic o_valid;
    logic o_active;
    logic o_wr_reject;
    int bad_count = 0;
    int total_checks = 0;

    always #20 i_clk = ~i_clk;

    sfdph_host_model sfdph_host_model_i (.o_req(req));
    sfdph_rom sfdph_rom_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_data(o_data),
        .o_valid(o_valid), .o_active(o_active), .o_wr_reject(o_wr_reject));

    // =================================================================
    // Expected content
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        case (a)
            24'h000000: return 8'h53;
            24'h000001: return 8'h46;
            24'h000002: return 8'h44;
            24'h000003: return 8'h50;
            24'h000004: return 8'h08;
            24'h000005, 24'h00000A, 24'h000012: return 8'h01;
            24'h000006: return 8'h01;
            24'h000008, 24'h00000D, 24'h00000E: return 8'h00;
            24'h000009: return 8'h07;
            24'h00000B: return 8'h10;
            24'h00000C: return 8'h30;
            24'h000010: return sfdph_pkg::H1_ID;
            24'h000011, 24'h000015, 24'h000016: return 8'h00;
            24'h000013: return 8'h03;
            24'h000014: return 8'h70;
            default: return 8'hFF;
        endcase
    endfunction

    // =================================================================
    // Compare and closing
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Open at a, read n bytes back to back, then close
    task automatic read_seq(input logic [23:0] a, input int n);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b1, 1'b0, 1'b0, 1'b0, a);
        @(negedge i_clk) check8({7'h00, o_active}, 8'h01);
        sfdph_host_model_i.drive(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk) check8({7'h00, o_valid}, 8'h01);
            check8(o_data, exp_byte(24'(a + i)));
            if (i == n - 1) begin
                sfdph_host_model_i.drive(1'b0, 1'b0, 1'b1, 1'b0, 24'h000000);
            end
        end
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
        check8({6'h00, o_active, o_valid}, 8'h00);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset();
        check8(o_data, 8'h00);
        check8({5'h00, o_valid, o_active, o_wr_reject}, 8'h00);
    endtask

    task automatic t_full_header();
        read_seq(24'h000000, 26);
        read_seq(24'hFFFFFE, 3);
    endtask

    task automatic t_restart();
        @(negedge i_clk) sfdph_host_model_i.drive(1'b1, 1'b0, 1'b0, 1'b0, 24'h000014);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
        @(negedge i_clk) check8(o_data, 8'h70);
        sfdph_host_model_i.drive(1'b1, 1'b0, 1'b0, 1'b0, 24'h00000B);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
        @(negedge i_clk) check8(o_data, 8'h10);
        // Stop with next in one cycle: the stop wins
        sfdph_host_model_i.drive(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
        check8({6'h00, o_active, o_valid}, 8'h00);
    endtask

    task automatic t_write();
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b1, 24'h000000);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
        check8({7'h00, o_wr_reject}, 8'h01);
        @(negedge i_clk) check8({7'h00, o_wr_reject}, 8'h00);
        read_seq(24'h000000, 4);
    endtask

    task automatic t_idle_next();
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b1, 1'b1, 1'b0, 24'h000000);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
        check8({6'h00, o_valid, o_active}, 8'h00);
    endtask

    task automatic t_mid_reset();
        @(negedge i_clk) sfdph_host_model_i.drive(1'b1, 1'b0, 1'b0, 1'b0, 24'h000010);
        @(negedge i_clk) sfdph_host_model_i.drive(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
        @(negedge i_clk) check8(o_data, sfdph_pkg::H1_ID);
        i_rst_n = 1'b0;
        sfdph_host_model_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
        @(negedge i_clk) i_rst_n = 1'b1;
        t_reset();
        read_seq(24'h000010, 2);
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_reset();
        t_full_header();
        t_restart();
        t_write();
        t_idle_next();
        t_mid_reset();
        report_and_stop();
    end

    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end
endmodule // tb_sfdph_rom
